// ---- rtl/display_vsync_cursor_position.sv ----
// vertical line counter, crt and panel vertical sync, frame-latched cursor x
// assumes a wishbone classic master and a line-rate enable from horizontal timing
`timescale 1ns/100ps
module display_vsync_cursor_position
#(
	parameter int line_w = 11
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic half_line_i,
	input wire logic line_end_i,
	output logic crt_vsync_o,
	output logic panel_vsync_o,
	output logic frame_start_o,
	output logic field_odd_o,
	output logic [10:0] cursor_x_o,
	output logic [4:0] cursor_col_o
);

	// state of the register file
	logic [31:0] crt_q, crt_d;
	logic [31:0] panel_q, panel_d;
	logic [31:0] curx_q, curx_d;
	logic [31:0] total_q, total_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	// timing state
	logic [line_w-1:0] line_q, line_d;
	logic field_q, field_d;
	logic crt_sync_q, crt_sync_d;
	logic panel_int_q, panel_int_d;
	logic panel_out_q, panel_out_d;
	logic frame_q, frame_d;
	vsync_cursor_pkg::cursor_pos_t cur_q, cur_d;

	logic req;
	logic wr;
	logic step;
	logic wrap;
	logic interlace;
	logic [10:0] vtotal;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// programmed value plus encoding bias gives the real line
	function automatic logic [10:0] decode(input logic [10:0] f, input logic [10:0] bias);
		return f + bias;
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign interlace = total_q[vsync_cursor_pkg::interlace_bit];
	assign vtotal = total_q[10:0];
	// line advance: half-line steps when interlaced
	assign step = interlace ? (half_line_i || line_end_i) : line_end_i;
	assign wrap = step && (line_q >= line_w'(vtotal - 11'h001));

	// write strobe; scan line register has no write path
	assign wr = req && wb_we_i;

	// crt sync timing register
	always_comb
	begin
		crt_d = crt_q;
		if (wr && wb_adr_i == vsync_cursor_pkg::crt_vsync_timing_off)
		begin
			crt_d = merge(crt_q, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			crt_q <= vsync_cursor_pkg::timing_reset;
		end
		else
		begin
			crt_q <= crt_d;
		end
	end

	// panel sync timing register
	always_comb
	begin
		panel_d = panel_q;
		if (wr && wb_adr_i == vsync_cursor_pkg::panel_vsync_timing_off)
		begin
			panel_d = merge(panel_q, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			panel_q <= vsync_cursor_pkg::timing_reset;
		end
		else
		begin
			panel_q <= panel_d;
		end
	end

	// cursor x register, software copy not yet shown
	always_comb
	begin
		curx_d = curx_q;
		if (wr && wb_adr_i == vsync_cursor_pkg::cursor_x_position_off)
		begin
			curx_d = merge(curx_q, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			curx_q <= vsync_cursor_pkg::cursor_reset;
		end
		else
		begin
			curx_q <= curx_d;
		end
	end

	// vertical total and interlace enable
	always_comb
	begin
		total_d = total_q;
		if (wr && wb_adr_i == vsync_cursor_pkg::line_total_off)
		begin
			total_d = merge(total_q, wb_dat_i, wb_sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			total_q <= vsync_cursor_pkg::total_reset;
		end
		else
		begin
			total_q <= total_d;
		end
	end

	// bus answer: ack one cycle after the request, read data registered
	always_comb
	begin
		ack_d = req;
		rdat_d = rdat_q;
		if (req && !wb_we_i)
		begin
			unique case (wb_adr_i)
				vsync_cursor_pkg::crt_vsync_timing_off:
					rdat_d = crt_q;
				vsync_cursor_pkg::panel_vsync_timing_off:
					rdat_d = panel_q;
				vsync_cursor_pkg::cursor_x_position_off:
					rdat_d = curx_q;
				vsync_cursor_pkg::current_scan_line_off:
					rdat_d = {21'h000000, 11'(line_q)};
				vsync_cursor_pkg::line_total_off:
					rdat_d = total_q;
				default:
					rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdat_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end
		else
		begin
			rdat_q <= rdat_d;
			ack_q <= ack_d;
		end
	end

	// compare lines decoded from the programmed fields
	logic [10:0] crt_on;
	logic [10:0] crt_off;
	logic [10:0] pan_on;
	logic [10:0] pan_off;
	logic [10:0] cmp;

	assign crt_on = decode(crt_q[vsync_cursor_pkg::start_msb:vsync_cursor_pkg::start_lsb],
		vsync_cursor_pkg::crt_bias);
	assign crt_off = decode(crt_q[vsync_cursor_pkg::end_msb:vsync_cursor_pkg::end_lsb],
		vsync_cursor_pkg::crt_bias);
	assign pan_on = decode(panel_q[vsync_cursor_pkg::start_msb:vsync_cursor_pkg::start_lsb],
		vsync_cursor_pkg::panel_bias);
	assign pan_off = decode(panel_q[vsync_cursor_pkg::end_msb:vsync_cursor_pkg::end_lsb],
		vsync_cursor_pkg::panel_bias);
	// compares use the line value this step moves to
	assign cmp = wrap ? 11'h000 : 11'(line_q + 1'b1);

	// line counter, field flag and frame start pulse
	always_comb
	begin
		line_d = line_q;
		field_d = field_q;
		frame_d = 1'b0;
		if (step)
		begin
			line_d = wrap ? '0 : line_q + 1'b1;
			// odd total in half steps: fields start half a line apart
			if (wrap)
			begin
				frame_d = 1'b1;
				field_d = interlace ? !field_q : 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			line_q <= '0;
			field_q <= 1'b0;
			frame_q <= 1'b0;
		end
		else
		begin
			line_q <= line_d;
			field_q <= field_d;
			frame_q <= frame_d;
		end
	end

	// crt sync, compared on every step so it follows half lines
	always_comb
	begin
		crt_sync_d = crt_sync_q;
		if (step && cmp == crt_on)
		begin
			crt_sync_d = 1'b1;
		end
		if (step && cmp == crt_off)
		begin
			crt_sync_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			crt_sync_q <= 1'b0;
		end
		else
		begin
			crt_sync_q <= crt_sync_d;
		end
	end

	// panel sync: internal level, then one output register stage
	always_comb
	begin
		panel_int_d = panel_int_q;
		panel_out_d = panel_int_q;
		if (step && cmp == pan_on)
		begin
			panel_int_d = 1'b1;
		end
		if (step && cmp == pan_off)
		begin
			panel_int_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			panel_int_q <= 1'b0;
			panel_out_q <= 1'b0;
		end
		else
		begin
			panel_int_q <= panel_int_d;
			panel_out_q <= panel_out_d;
		end
	end

	// cursor copy taken only at frame start, so no tearing mid-frame
	always_comb
	begin
		cur_d = cur_q;
		if (step && wrap)
		begin
			cur_d.x = curx_q[10:0];
			cur_d.xoff = curx_q[vsync_cursor_pkg::xoff_msb:vsync_cursor_pkg::xoff_lsb];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cur_q <= '0;
		end
		else
		begin
			cur_q <= cur_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign crt_vsync_o = crt_sync_q;
	assign panel_vsync_o = panel_out_q;
	assign frame_start_o = frame_q;
	assign field_odd_o = field_q;
	assign cursor_x_o = cur_q.x;
	// first visible pattern column; pixels left of it are skipped
	assign cursor_col_o = cur_q.xoff;

endmodule // display_vsync_cursor_position

// ---- rtl/vsync_cursor_pkg.sv ----
// package: register map, field layout and carrier types for the vertical sync
// and cursor position block; no assumptions beyond a 32-bit classic wishbone
package vsync_cursor_pkg;
	localparam logic [15:0] crt_vsync_timing_off = 16'h8348;
	localparam logic [15:0] panel_vsync_timing_off = 16'h834c;
	localparam logic [15:0] cursor_x_position_off = 16'h8350;
	localparam logic [15:0] current_scan_line_off = 16'h8354;
	localparam logic [15:0] line_total_off = 16'h8360;
	localparam int line_w = 11;
	localparam int end_lsb = 16;
	localparam int end_msb = 26;
	localparam int start_lsb = 0;
	localparam int start_msb = 10;
	localparam int xoff_lsb = 11;
	localparam int xoff_msb = 15;
	localparam int interlace_bit = 31;
	localparam logic [10:0] crt_bias = 11'h001;
	localparam logic [10:0] panel_bias = 11'h002;
	localparam logic [31:0] timing_reset = 32'h0000_0000;
	localparam logic [31:0] cursor_reset = 32'h0000_0000;
	localparam logic [31:0] total_reset = 32'h0000_020d;
	localparam logic [10:0] hpix_reset = 11'h320;
	typedef struct packed
	{
		logic [10:0] x;
		logic [4:0] xoff;
	} cursor_pos_t;
	typedef struct packed
	{
		logic crt_vsync;
		logic panel_vsync;
		logic frame_start;
		logic field_odd;
	} sync_out_t;
endpackage

// ---- verification/vsync_cursor_asserts.sv ----
// checker: bus answer, sync steps and cursor latching at the top ports
// assumes bind onto the top module, one clock, sync reset
`timescale 1ns/100ps
module vsync_cursor_asserts
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic half_line_i,
	input wire logic line_end_i,
	input wire logic crt_vsync_o,
	input wire logic panel_vsync_o,
	input wire logic frame_start_o,
	input wire logic [10:0] cursor_x_o,
	input wire logic [4:0] cursor_col_o
);
	logic step;
	assign step = line_end_i | half_line_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence wrap_s;
		$past(step) ##1 !frame_start_o;
	endsequence
	a_ack_latency: assert property (req_s |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_unmapped_zero: assert property (req_s ##0 (!wb_we_i && wb_adr_i[15:8] != 8'h83)
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_frame_on_wrap: assert property (frame_start_o |-> wrap_s)
		else $error("frame start off step");
	a_cursor_x_hold: assert property ($changed(cursor_x_o) |-> frame_start_o)
		else $error("cursor x moved mid frame");
	a_cursor_col_hold: assert property ($changed(cursor_col_o) |-> frame_start_o)
		else $error("cursor offset moved mid frame");
	a_crt_on_step: assert property ($changed(crt_vsync_o) |-> $past(step))
		else $error("crt sync off step");
	a_panel_lag: assert property ($changed(panel_vsync_o) |-> $past(step, 2))
		else $error("panel sync not delayed");
endmodule // vsync_cursor_asserts
bind display_vsync_cursor_position vsync_cursor_asserts vsync_cursor_asserts_i (.*);

// ---- verification/display_sink.sv ----
// partner: display end counting the vertical sync pulses it receives
// assumes active-high sync levels on the pixel clock
`timescale 1ns/100ps
module display_sink
(
	input wire logic clk_i,
	input wire logic crt_vsync_i,
	input wire logic panel_vsync_i,
	output int crt_pulses_o = 0,
	output int panel_pulses_o = 0
);
	logic crt_q = 1'b0;
	logic pan_q = 1'b0;
	always @(posedge clk_i)
	begin
		crt_q <= crt_vsync_i;
		pan_q <= panel_vsync_i;
		if (crt_vsync_i && !crt_q) crt_pulses_o <= crt_pulses_o + 1;
		if (panel_vsync_i && !pan_q) panel_pulses_o <= panel_pulses_o + 1;
	end
endmodule // display_sink

// ---- verification/display_vsync_cursor_position_tb.sv ----
// testbench: registers, sync placement per step, frame-latched cursor
// assumes the design package and a 20 MHz pixel clock
`timescale 1ns/100ps
module display_vsync_cursor_position_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [15:0] wb_adr_i = 16'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic half_line_i = 1'b0;
	logic line_end_i = 1'b0;
	logic [31:0] wb_dat_o, rd, cur, old;
	logic wb_ack_o, crt_vsync_o, panel_vsync_o, frame_start_o, field_odd_o;
	logic [10:0] cursor_x_o;
	logic [4:0] cursor_col_o;
	logic [31:0] seed = 32'h46;
	int crt_n, pan_n, fails = 0, compares = 0, cnt = 0, tot, cs, ce, ps, pe;
	always #25 clk_i = ~clk_i;
	display_vsync_cursor_position display_vsync_cursor_position_i (.*);
	display_sink display_sink_i (.clk_i(clk_i), .crt_vsync_i(crt_vsync_o),
		.panel_vsync_i(panel_vsync_o), .crt_pulses_o(crt_n), .panel_pulses_o(pan_n));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic win(input int b, input int e);
		return cnt >= b && cnt < e;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic step(input logic h);
		@(posedge clk_i);
		if (h) half_line_i <= 1'b1;
		else line_end_i <= 1'b1;
		@(posedge clk_i);
		half_line_i <= 1'b0;
		line_end_i <= 1'b0;
		cnt = (cnt + 1) % tot;
		repeat (2) @(posedge clk_i);
		#1;
		chk("crt_vsync", win(cs + 1, ce + 1), crt_vsync_o);
		chk("panel_vsync", win(ps + 2, pe + 2), panel_vsync_o);
		bus(0, 16'h8354, 0);
		chk("scan_line", cnt, rd);
	endtask
	task automatic tim(input int a, input int b, input int c, input int d);
		cs = a;
		ce = b;
		ps = c;
		pe = d;
		bus(1, 16'h8348, b << 16 | a);
		bus(1, 16'h834c, d << 16 | c);
		bus(0, 16'h834c, 0);
		chk("panel_timing", d << 16 | c, rd);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, 16'h8360, 0);
		chk("line_total", 32'h20d, rd);
		bus(1, 16'h8354, rnd() & 32'h7ff);
		bus(0, 16'h8354, 0);
		chk("scan_line", 0, rd);
		bus(0, 16'h1000, 0);
		chk("unmapped", 0, rd);
		wb_sel_i <= 4'h2;
		bus(1, 16'h8350, 32'hffff_ffff);
		wb_sel_i <= 4'hf;
		bus(0, 16'h8350, 0);
		chk("cursor_lane", 32'h0000_ff00, rd);
		tot = 20;
		old = 0;
		bus(1, 16'h8360, tot);
		tim(3, 6, 3, 6);
		for (int f = 1; f <= 2; f++)
		begin
			cur = (f == 1) ? rnd() & 32'hffff : 32'hffff;
			bus(1, 16'h8350, cur);
			repeat (tot - 1) step(0);
			chk("cursor_hold", old[10:0], cursor_x_o);
			step(0);
			chk("cursor_x", cur[10:0], cursor_x_o);
			chk("cursor_col", cur[15:11], cursor_col_o);
			chk("crt_pulses", f, crt_n);
			chk("panel_pulses", f, pan_n);
			old = cur;
		end
		tot = 5;
		bus(1, 16'h8360, 32'h8000_0005);
		tim(1, 2, 0, 1);
		for (int k = 1; k <= 10; k++)
		begin
			step(k[0]);
			if (k % 5 == 0) chk("field_odd", k == 5, field_odd_o);
		end
		tally_and_finish();
	end
	initial
	begin
		#1000000;
		fails++;
		tally_and_finish();
	end
endmodule // display_vsync_cursor_position_tb
